// ===== design/see_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "see_regs.svh"
// Function
// - Master may use select bits as address
// - Pointer stays inside own array
// - Acknowledge matching control byte on ninth clock
// - Word address loads address pointer
// - Stop starts internal write cycle
// - No acknowledge while write cycle runs
// - Protected writes acknowledged, array unchanged
// - Blocked writes still run busy period
// - Up to sixteen bytes buffered until Stop
// - Page write increments low nibble only
// - Extra bytes wrap and overwrite page
// - Master keeps page writes inside page
// - Protect input high protects whole array
// - Master repeats control byte until acknowledged
// - Acknowledge polling once cycle finishes
// - Read bit one starts read
// - Current read uses address counter
// - Missing master acknowledge stops data
// - Repeated start keeps word address
// - Acknowledged read byte sends next word
// - Read pointer wraps top to zero
// - Respond only to code and pins
// - Release data line after no acknowledge
module see_device #(
   parameter int WRITE_CYCLES = `SEE_WRITE_CYCLES
) (
   input  wire logic         ref_clk,   // System clock
   input  wire logic         sys_rst,   // Async reset, high
   see_bus_if.device         bus,       // Two-wire bus
   input  wire see_pkg::see_csel_t chipSel, // Select pin levels
   input  wire logic         wrProtect, // Write protect pin
   output logic              busy       // Write cycle running
);
   import see_pkg::*;
   typedef enum {
      ST_IDLE, ST_CTRL, ST_ADDR, ST_WDATA, ST_RDATA, ST_RACK, ST_ACK, ST_WAIT
   } see_dst_t;

   logic [2:0] sclSync_r;
   logic [2:0] sdaSync_r;
   logic       sclRise;
   logic       sclFall;
   logic       startSeen;
   logic       stopSeen;
   see_dst_t   state_r;
   see_dst_t   ackNext_r;
   logic [2:0] bitCnt_r;
   see_byte_t  shift_r;
   see_byte_t  ptr_r;
   see_byte_t  mem_r [`SEE_ARRAY_DEPTH];
   see_byte_t  page_r [`SEE_PAGE_SIZE];
   logic [`SEE_PAGE_SIZE-1:0] pageVld_r;
   logic       pending_r;
   logic [31:0] busyCnt_r;
   logic       protLatch_r;
   logic       sdaOut_r;
   logic       sdaOe_r;
   logic       isRead_r;
   logic       rxFull_r;
   see_csel_t  selS1_r;
   see_csel_t  selS2_r;
   logic       wpS1_r;
   logic       wpS2_r;

   // One flop first, taps only on later stages
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclSync_r <= 3'h7;
         sdaSync_r <= 3'h7;
      end else begin
         sclSync_r <= {sclSync_r[1:0], bus.scl};
         sdaSync_r <= {sdaSync_r[1:0], bus.sda};
      end
   end
   // Strapped pins are static but still cross two flops
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         selS1_r <= 3'h0;
         selS2_r <= 3'h0;
         wpS1_r  <= 1'b0;
         wpS2_r  <= 1'b0;
      end else begin
         selS1_r <= chipSel;
         selS2_r <= selS1_r;
         wpS1_r  <= wrProtect;
         wpS2_r  <= wpS1_r;
      end
   end
   assign sclRise   = sclSync_r[1] && !sclSync_r[2];
   assign sclFall   = !sclSync_r[1] && sclSync_r[2];
   assign startSeen = sclSync_r[1] && sclSync_r[2] && !sdaSync_r[1] && sdaSync_r[2];
   assign stopSeen  = sclSync_r[1] && sclSync_r[2] && sdaSync_r[1] && !sdaSync_r[2];

   // Protocol state machine
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r   <= ST_IDLE;
         ackNext_r <= ST_IDLE;
         bitCnt_r  <= 3'h0;
         shift_r   <= 8'h00;
         ptr_r     <= 8'h00;
         sdaOut_r  <= 1'b1;
         sdaOe_r   <= 1'b0;
         isRead_r  <= 1'b0;
         pageVld_r <= '0;
         pending_r <= 1'b0;
         rxFull_r  <= 1'b0;
      end else if (startSeen) begin
         state_r  <= ST_CTRL;
         bitCnt_r <= 3'h0;
         sdaOe_r  <= 1'b0;
         rxFull_r <= 1'b0;
         // Polls during a write cycle must not drop the buffered page
         if (pending_r == 1'b0 && !busy) begin
            pageVld_r <= '0;
         end
      end else if (stopSeen) begin
         state_r <= ST_IDLE;
         sdaOe_r <= 1'b0;
         if (|pageVld_r && busyCnt_r == 32'h0) begin
            pending_r <= 1'b1;
         end
      end else begin
         if (pending_r && busyCnt_r != 32'h0) begin
            pending_r <= 1'b0;
         end
         if (busy && busyCnt_r == 32'h1) begin
            pageVld_r <= '0;
         end
         case (state_r)
            ST_CTRL, ST_ADDR, ST_WDATA: begin
               if (sclRise) begin
                  shift_r  <= {shift_r[6:0], sdaSync_r[1]};
                  bitCnt_r <= bitCnt_r + 3'h1;
                  rxFull_r <= (bitCnt_r == 3'h7);
               end
               // The fall right after a start is not a byte end
               if (sclFall && rxFull_r) begin
                  rxFull_r <= 1'b0;
                  state_r <= ST_ACK;
                  if (state_r == ST_CTRL) begin
                     if (shift_r[7:4] == `SEE_DEV_CODE && shift_r[3:1] == selS2_r && !busy && !pending_r) begin
                        sdaOut_r <= 1'b0;
                        sdaOe_r  <= 1'b1;
                        isRead_r <= shift_r[0];
                        ackNext_r <= shift_r[0] ? ST_RDATA : ST_ADDR;
                     end else begin
                        state_r <= ST_WAIT;
                     end
                  end else if (state_r == ST_ADDR) begin
                     ptr_r     <= shift_r;
                     sdaOut_r  <= 1'b0;
                     sdaOe_r   <= 1'b1;
                     ackNext_r <= ST_WDATA;
                  end else begin
                     pageVld_r[ptr_r[3:0]] <= 1'b1;
                     ptr_r     <= {ptr_r[7:4], ptr_r[3:0] + 4'h1};
                     sdaOut_r  <= 1'b0;
                     sdaOe_r   <= 1'b1;
                     ackNext_r <= ST_WDATA;
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  state_r  <= ackNext_r;
                  bitCnt_r <= 3'h0;
                  if (ackNext_r == ST_RDATA) begin
                     sdaOut_r <= mem_r[ptr_r][7];
                     sdaOe_r  <= 1'b1;
                     shift_r  <= {mem_r[ptr_r][6:0], 1'b0};
                     bitCnt_r <= 3'h1;
                     ptr_r    <= ptr_r + 8'h01;
                  end else begin
                     sdaOe_r <= 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (sclFall) begin
                  if (bitCnt_r == 3'h0) begin
                     state_r <= ST_RACK;
                     sdaOe_r <= 1'b0;
                  end else begin
                     sdaOut_r <= shift_r[7];
                     shift_r  <= {shift_r[6:0], 1'b0};
                     bitCnt_r <= bitCnt_r + 3'h1;
                  end
               end
            end
            ST_RACK: begin
               if (sclRise) begin
                  if (sdaSync_r[1]) begin
                     state_r <= ST_WAIT;
                  end else begin
                     state_r   <= ST_ACK;
                     ackNext_r <= ST_RDATA;
                  end
               end
            end
            ST_WAIT: sdaOe_r <= 1'b0;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Page buffer capture
   always_ff @(posedge ref_clk) begin
      if (state_r == ST_WDATA && sclFall && rxFull_r && !stopSeen && !startSeen) begin
         page_r[ptr_r[3:0]] <= shift_r;
      end
   end

   // timed busy, runs even when protected
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busyCnt_r   <= 32'h0;
         busy        <= 1'b0;
         protLatch_r <= 1'b0;
      end else if (pending_r && busyCnt_r == 32'h0) begin
         busyCnt_r   <= WRITE_CYCLES;
         busy        <= 1'b1;
         protLatch_r <= wpS2_r;
      end else if (busyCnt_r != 32'h0) begin
         busyCnt_r <= busyCnt_r - 32'h1;
         busy      <= (busyCnt_r != 32'h1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (busy && busyCnt_r == 32'h1 && !protLatch_r) begin
         for (int i = 0; i < `SEE_PAGE_SIZE; i++) begin
            if (pageVld_r[i]) begin
               mem_r[{ptr_r[7:4], 4'(i)}] <= page_r[i];
            end
         end
      end
   end

   assign bus.sdaDevOut = sdaOut_r;
   assign bus.sdaDevOe  = sdaOe_r;
endmodule
`default_nettype wire

// ===== design/see_regs.svh
`ifndef SEE_REGS_SVH
`define SEE_REGS_SVH
`define SEE_DEV_CODE      4'ha
`define SEE_ARRAY_DEPTH   256
`define SEE_PAGE_SIZE     16
`define SEE_CLK_PERIOD_NS 25
`define SEE_WRITE_TIME_NS 5000
`define SEE_WRITE_CYCLES  ((`SEE_WRITE_TIME_NS + `SEE_CLK_PERIOD_NS - 1) / `SEE_CLK_PERIOD_NS)
`define SEE_SCL_HALF      4
`endif

// ===== design/see_pkg.sv
package see_pkg;
   typedef logic [7:0] see_byte_t;
   typedef logic [2:0] see_csel_t;
   typedef enum logic [1:0] {
      SEE_OP_WRITE,
      SEE_OP_CUR_READ,
      SEE_OP_RAND_READ
   } see_op_t;
endpackage

// ===== design/see_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface see_bus_if;
   logic sclOut;
   logic sdaMstOut;
   logic sdaMstOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic scl;
   logic sda;
   // Open drain wire with pull-up
   assign scl = sclOut;
   assign sda = !((sdaMstOe && !sdaMstOut) || (sdaDevOe && !sdaDevOut));
   modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
   modport master (input sda, output sclOut, output sdaMstOut, output sdaMstOe);
endinterface
`default_nettype wire

// ===== design/see_master.sv
`timescale 1ns/100ps
`default_nettype none
`include "see_regs.svh"
// are the caller's duty: it forms addresses and retries on noAck
module see_master (
   input  wire logic               ref_clk,  // System clock
   input  wire logic               sys_rst,  // Async reset, high
   see_bus_if.master               bus,      // Two-wire bus
   input  wire logic               cmdValid, // Start a command
   input  wire see_pkg::see_op_t   cmdOp,    // Operation kind
   input  wire see_pkg::see_csel_t cmdSel,   // Device select
   input  wire see_pkg::see_byte_t cmdAddr,  // Word address
   input  wire see_pkg::see_byte_t cmdData,  // Write byte
   output logic                    cmdBusy,  // Command running
   output logic                    doneStb,  // Command finished
   output logic                    noAck,    // Device refused
   output see_pkg::see_byte_t      rdData    // Read byte
);
   import see_pkg::*;
   typedef enum {M_IDLE, M_START, M_BITS, M_STOP, M_END} see_mst_t;
   see_mst_t    st_r;
   logic [2:0]  ph_r;
   logic [3:0]  bitIdx_r;
   logic [1:0]  byteIdx_r;
   logic [2:0]  div_r;
   logic [8:0]  tx_r;
   logic        sdaS1_r;
   logic        sdaS2_r;
   logic        scl_r;
   logic        sdaO_r;
   see_op_t     op_r;
   see_byte_t   addr_r;
   see_byte_t   data_r;
   see_csel_t   sel_r;
   logic        rep_r;
   logic        tick;

   // Input synchroniser
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdaS1_r <= 1'b1;
         sdaS2_r <= 1'b1;
      end else begin
         sdaS1_r <= bus.sda;
         sdaS2_r <= sdaS1_r;
      end
   end

   // Clock divider, quarter phases
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r <= 3'h0;
      end else begin
         div_r <= (div_r == 3'(`SEE_SCL_HALF - 1)) ? 3'h0 : div_r + 3'h1;
      end
   end
   assign tick = (div_r == 3'h0);

   // Sequencer; one bit is four ticks, sample at the third
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= M_IDLE; ph_r <= 3'h0; bitIdx_r <= 4'h0; byteIdx_r <= 2'h0;
         tx_r <= 9'h1ff; scl_r <= 1'b1; sdaO_r <= 1'b1; cmdBusy <= 1'b0;
         doneStb <= 1'b0; noAck <= 1'b0; rdData <= 8'h00; op_r <= SEE_OP_WRITE;
         addr_r <= 8'h00; data_r <= 8'h00; sel_r <= 3'h0; rep_r <= 1'b0;
      end else begin
         doneStb <= 1'b0;
         case (st_r)
            M_IDLE: begin
               if (cmdValid) begin
                  op_r <= cmdOp; sel_r <= cmdSel; addr_r <= cmdAddr; data_r <= cmdData;
                  cmdBusy <= 1'b1; noAck <= 1'b0; rep_r <= 1'b0; byteIdx_r <= 2'h0;
                  st_r <= M_START; ph_r <= 3'h0;
               end
            end
            M_START: if (tick) begin
               ph_r <= ph_r + 3'h1;
               if (ph_r == 3'h0) begin sdaO_r <= 1'b1; scl_r <= 1'b1; end
               if (ph_r == 3'h1) sdaO_r <= 1'b0;
               if (ph_r == 3'h2) begin
                  scl_r <= 1'b0; ph_r <= 3'h0; bitIdx_r <= 4'h0; st_r <= M_BITS;
                  tx_r <= {`SEE_DEV_CODE, sel_r,
                     (op_r == SEE_OP_CUR_READ) || (op_r == SEE_OP_RAND_READ && rep_r), 1'b1};
               end
            end
            M_BITS: if (tick) begin
               ph_r <= ph_r + 3'h1;
               if (ph_r == 3'h0) sdaO_r <= tx_r[8];
               if (ph_r == 3'h1) scl_r <= 1'b1;
               if (ph_r == 3'h2) tx_r <= {tx_r[7:0], sdaS2_r};
               if (ph_r == 3'h3) begin
                  scl_r <= 1'b0; ph_r <= 3'h0; bitIdx_r <= bitIdx_r + 4'h1;
                  if (bitIdx_r == 4'h8) begin
                     bitIdx_r <= 4'h0; byteIdx_r <= byteIdx_r + 2'h1;
                     if (tx_r[0] && (byteIdx_r == 2'h0 || op_r == SEE_OP_WRITE || byteIdx_r == 2'h1)
                         && !((op_r == SEE_OP_CUR_READ || rep_r) && byteIdx_r == 2'h1)) begin
                        noAck <= 1'b1; st_r <= M_STOP;
                     end else if (op_r == SEE_OP_WRITE) begin
                        if (byteIdx_r == 2'h2) st_r <= M_STOP;
                        tx_r <= {(byteIdx_r == 2'h0) ? addr_r : data_r, 1'b1};
                     end else if (op_r == SEE_OP_RAND_READ && !rep_r && byteIdx_r == 2'h1) begin
                        // Repeated start counts its bytes afresh
                        rep_r <= 1'b1;
                        st_r <= M_START;
                        byteIdx_r <= 2'h0;
                     end else if (byteIdx_r == 2'h0) begin
                        tx_r <= (op_r == SEE_OP_CUR_READ || rep_r) ? 9'h1ff : {addr_r, 1'b1};
                     end else begin
                        rdData <= tx_r[8:1]; st_r <= M_STOP;
                     end
                  end
               end
            end
            M_STOP: if (tick) begin
               ph_r <= ph_r + 3'h1;
               if (ph_r == 3'h0) sdaO_r <= 1'b0;
               if (ph_r == 3'h1) scl_r <= 1'b1;
               if (ph_r == 3'h2) begin sdaO_r <= 1'b1; st_r <= M_END; end
            end
            M_END: begin
               cmdBusy <= 1'b0; doneStb <= 1'b1; st_r <= M_IDLE;
            end
            default: st_r <= M_IDLE;
         endcase
      end
   end

   assign bus.sclOut    = scl_r;
   assign bus.sdaMstOut = sdaO_r;
   assign bus.sdaMstOe  = !sdaO_r;
endmodule
`default_nettype wire

// ===== test/see_bus_chk.sv
`timescale 1ns/100ps
`default_nettype none
module see_bus_chk #(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic ref_clk,   // System clock
   input wire logic sys_rst,   // Async reset, high
   input wire logic scl,       // Resolved clock line
   input wire logic sda,       // Resolved data line
   input wire logic sdaDevOut, // Device data out
   input wire logic sdaDevOe,  // Device drive enable
   input wire logic busy       // Device write cycle
);
   // Slack for the stop synchroniser and counter alignment
   localparam int BUSY_MIN = WRITE_CYCLES - 2;
   localparam int BUSY_MAX = WRITE_CYCLES + 2;
   logic        sclD_r;
   logic        sdaD_r;
   logic        inFrame_r;
   logic [4:0]  bitCnt_r;
   logic [3:0]  sinceStop_r;
   logic [15:0] busyCnt_r;
   logic        devLow;
   logic        startDet;
   logic        stopDet;
   // Line conditions seen at the block clock
   assign devLow   = sdaDevOe && !sdaDevOut;
   assign startDet = scl && sclD_r && sdaD_r && !sda;
   assign stopDet  = scl && sclD_r && !sdaD_r && sda;
   // Delayed line copies for edge finding
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclD_r <= 1'b1;
         sdaD_r <= 1'b1;
      end else begin
         sclD_r <= scl;
         sdaD_r <= sda;
      end
   end
   // Frame tracking and clock pulse count, saturating
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         inFrame_r <= 1'b0;
         bitCnt_r  <= 5'h00;
      end else begin
         inFrame_r <= startDet ? 1'b1 : (stopDet ? 1'b0 : inFrame_r);
         if (startDet)
            bitCnt_r <= 5'h00;
         else if (scl && !sclD_r && bitCnt_r != 5'h1f)
            bitCnt_r <= bitCnt_r + 5'h01;
      end
   end
   // Age of last stop; starts saturated so reset cannot fake one
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         sinceStop_r <= 4'hf;
      else if (stopDet)
         sinceStop_r <= 4'h0;
      else if (sinceStop_r != 4'hf)
         sinceStop_r <= sinceStop_r + 4'h1;
   end
   // Length of the current busy period
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         busyCnt_r <= 16'h0000;
      else
         busyCnt_r <= busy ? busyCnt_r + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_busy_start;
      $rose(busy);
   endsequence
   sequence s_first_drive;
      $rose(devLow) && bitCnt_r < 5'h09;
   endsequence
   a_busy_no_ack: assert property (busy |-> !devLow) else $error("device drove line while busy");
   a_busy_after_stop: assert property (s_busy_start |-> !inFrame_r && sinceStop_r <= 4'h6)
      else $error("write cycle began without stop");
   a_busy_hold_min: assert property (s_busy_start |=> busy [*8]) else $error("write cycle too short");
   a_busy_length: assert property ($fell(busy) |-> busyCnt_r >= BUSY_MIN && busyCnt_r <= BUSY_MAX)
      else $error("write cycle length wrong");
   a_ack_ninth_clock: assert property (s_first_drive |-> bitCnt_r == 5'h08)
      else $error("control acknowledge off ninth clock");
   a_silent_outside: assert property (!inFrame_r |-> !devLow) else $error("device drove outside frame");
   a_change_scl_low: assert property ($changed(devLow) |-> !scl) else $error("device data changed with clock high");
   a_hold_scl_high: assert property (scl && devLow |=> devLow || !scl)
      else $error("device released line during clock high");
   c_write_cycle: cover property (s_busy_start);
endmodule
`default_nettype wire

// ===== test/see_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "see_regs.svh"
module see_tb;
   import see_pkg::*;
   // Long enough that the first poll always lands inside the cycle
   localparam int WC = 300;
   logic ref_clk, sys_rst, cmdValid, wp, cmdBusy, doneStb, noAck, devBusy, sclQ, sdaQ;
   see_op_t   cmdOp;
   see_csel_t cmdSel, devSel;
   see_byte_t cmdAddr, cmdData, rdData, monByte, a, old;
   see_byte_t mem [256];
   logic [31:0] seed = 32'h00006573;
   logic [31:0] r;
   int monCnt, err_count, check_count, t, i;
   see_bus_if busIf ();
   see_device #(.WRITE_CYCLES(WC)) see_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(busIf),
      .chipSel(devSel), .wrProtect(wp), .busy(devBusy));
   see_master see_master_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(busIf), .cmdValid(cmdValid),
      .cmdOp(cmdOp), .cmdSel(cmdSel), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdBusy(cmdBusy),
      .doneStb(doneStb), .noAck(noAck), .rdData(rdData));
   see_bus_chk #(.WRITE_CYCLES(WC)) see_bus_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl(busIf.scl),
      .sda(busIf.sda), .sdaDevOut(busIf.sdaDevOut), .sdaDevOe(busIf.sdaDevOe), .busy(devBusy));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Capture the first byte of each frame off the wire
   always @(posedge ref_clk) begin
      sclQ <= busIf.scl;
      sdaQ <= busIf.sda;
      if (busIf.scl && sclQ && sdaQ && !busIf.sda)
         monCnt <= 0;
      else if (busIf.scl && !sclQ && monCnt < 8) begin
         monByte <= {monByte[6:0], busIf.sda};
         monCnt  <= monCnt + 1;
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input bit ok, input string msg);
      check_count++;
      if (!ok) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   // One command, then a bounded wait for its done strobe
   task automatic cmd(input see_op_t op, input see_csel_t sel, input see_byte_t ad, input see_byte_t d);
      int n;
      @(posedge ref_clk) #2;
      cmdValid = 1'b1;
      cmdOp    = op;
      cmdSel   = sel;
      cmdAddr  = ad;
      cmdData  = d;
      @(posedge ref_clk) #2;
      cmdValid = 1'b0;
      chk(cmdBusy === 1'b1, "command not taken");
      for (n = 0; n < 4000 && doneStb !== 1'b1; n++)
         @(posedge ref_clk) #2;
      if (n == 4000) begin
         err_count++;
         $display("[FAIL] %0t command hang", $time);
         summarize();
      end
      chk(cmdBusy === 1'b0, "busy after done");
   endtask
   // repeat control byte
   // Polls with a write-direction control byte until acknowledged
   task automatic poll(input see_byte_t ad, output int tries);
      tries = 0;
      do begin
         cmd(SEE_OP_RAND_READ, devSel, ad, 8'h00);
         tries++;
      end while (noAck === 1'b1 && tries < 40);
   endtask
   task automatic wr(input see_byte_t ad, input see_byte_t d);
      cmd(SEE_OP_WRITE, devSel, ad, d);
      mem[ad] = d;
      chk(noAck === 1'b0, "write refused");
      chk(monByte === {`SEE_DEV_CODE, devSel, 1'b0}, "control byte order");
      poll(ad, t);
      chk(t > 1 && t < 40, "poll count");
      chk(rdData === d && noAck === 1'b0, "read back");
      chk(busIf.sda === 1'b1 && busIf.scl === 1'b1, "lines not released");
   endtask
   initial begin
      sys_rst = 1'b1;
      cmdValid = 1'b0;
      cmdOp = SEE_OP_WRITE;
      cmdSel = 3'h0;
      cmdAddr = 8'h00;
      cmdData = 8'h00;
      wp = 1'b0;
      devSel = 3'h5;
      monByte = 8'h00;
      monCnt = 8;
      repeat (3) @(posedge ref_clk);
      #2 sys_rst = 1'b0;
      chk(busIf.sda === 1'b1 && busIf.scl === 1'b1, "bus not idle");
      // Neighbours plus both ends of the pointer range
      r = xs();
      a = r[7:0];
      wr(a, r[15:8]);
      wr(a + 8'h01, r[23:16]);
      wr(8'hff, r[31:24]);
      wr(8'h00, ~r[7:0]);
      $display("test write and poll done");
      cmd(SEE_OP_RAND_READ, devSel, a, 8'h00);
      chk(rdData === mem[a], "random read");
      cmd(SEE_OP_CUR_READ, devSel, 8'h00, 8'h00);
      chk(rdData === mem[a + 8'h01], "current read");
      cmd(SEE_OP_RAND_READ, devSel, 8'hff, 8'h00);
      cmd(SEE_OP_CUR_READ, devSel, 8'h00, 8'h00);
      chk(rdData === mem[8'h00] && noAck === 1'b0, "pointer wrap");
      $display("test pointer done");
      // Protected write: acknowledged, busy, array untouched
      wp = 1'b1;
      old = mem[a];
      cmd(SEE_OP_WRITE, devSel, a, ~old);
      chk(noAck === 1'b0, "protected write refused");
      poll(a, t);
      chk(t > 1 && t < 40, "protected busy period");
      chk(rdData === old, "protected data changed");
      wp = 1'b0;
      $display("test protect done");
      for (i = 0; i < 3; i++) begin
         cmd(SEE_OP_CUR_READ, devSel ^ see_csel_t'(3'h1 << i), 8'h00, 8'h00);
         chk(noAck === 1'b1, "foreign select answered");
      end
      $display("test select done");
      // select moves, single bytes stay in page
      repeat (8) begin
         r = xs();
         devSel = r[2:0];
         wr(r[15:8], r[23:16]);
      end
      $display("test random done");
      summarize();
   end
endmodule
`default_nettype wire
